// ### ccr_pkg.sv
package ccr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CCR_IDX_CHAN0_CONFIG   = 8'h09;
  localparam logic [7:0] CCR_IDX_CH0_OFS_U = 8'h0a;
  localparam logic [7:0] CCR_IDX_CH0_OFS_L = 8'h0b;
  localparam logic [7:0] CCR_IDX_CH0_GN_U  = 8'h0c;
  localparam logic [7:0] CCR_IDX_CH0_GN_L  = 8'h0d;
  localparam logic [7:0] CCR_IDX_CHAN1_CONFIG   = 8'h0e;
  localparam logic [7:0] CCR_IDX_CH1_OFS_U = 8'h0f;
  localparam logic [7:0] CCR_IDX_CH1_OFS_L = 8'h10;
  localparam logic [7:0] CCR_IDX_COMMIT    = 8'h18;

  localparam int CCR_ADDR_W  = 12;
  localparam int CCR_IDX_LSB = 2;

  // Field positions
  localparam int CCR_PHASE_HI = 15;
  localparam int CCR_PHASE_LO = 6;
  localparam int CCR_MUX_HI   = 1;
  localparam int CCR_MUX_LO   = 0;
  localparam int CCR_LOW_HI   = 15;
  localparam int CCR_LOW_LO   = 8;

  // Reset values
  localparam logic [15:0] CCR_RST_ZERO    = 16'h0000;
  localparam logic [15:0] CCR_RST_GAIN_U  = 16'h8000;
  localparam logic [23:0] CCR_RST_GAIN_24 = 24'h80_0000;

  // Writable bit masks; all other bits read zero
  localparam logic [15:0] CCR_MASK_CFG  = 16'hffc3;
  localparam logic [15:0] CCR_MASK_UP   = 16'hffff;
  localparam logic [15:0] CCR_MASK_LOW  = 16'hff00;

  typedef enum logic [1:0] {
    CCR_MUX_PINS,
    CCR_MUX_SHORTED,
    CCR_MUX_DC_DIAG,
    CCR_MUX_AC_DIAG
  } ccr_mux_t;

  typedef struct packed {
    logic [9:0] phase_delay;
    ccr_mux_t   input_select;
  } ccr_chan_cfg_t;

  typedef struct packed {
    logic [23:0] chan0_offset;
    logic [23:0] chan0_gain;
    logic [23:0] chan1_offset;
  } ccr_cal_t;

endpackage

// ### ccr_apb_slave.sv
`timescale 1ns/100ps
module ccr_apb_slave
  import ccr_pkg::*;
(
  input  wire logic                  pclk,       // Bus clock
  input  wire logic                  presetn,    // Async reset, low
  input  wire logic                  psel,       // Select
  input  wire logic                  penable,    // Access phase
  input  wire logic                  pwrite,     // Direction
  input  wire logic [CCR_ADDR_W-1:0] paddr,      // Byte address
  output logic                       wr_stb,     // One-cycle write strobe
  output logic                       rd_stb,     // One-cycle read strobe
  output logic [7:0]                 reg_idx,    // Word index
  output logic                       misaligned  // Address not word aligned
);

  // Zero wait states: every access completes in its first access cycle
  always_comb begin
    wr_stb     = psel && penable && pwrite;
    rd_stb     = psel && penable && !pwrite;
    reg_idx    = 8'(paddr[CCR_ADDR_W-1:CCR_IDX_LSB]);
    misaligned = paddr[CCR_IDX_LSB-1:0] != 2'b00;
  end

endmodule

// ### ccr_regs.sv
`timescale 1ns/100ps
// What this block does
// (RULE_01) Channel 0 config bits 15..6 hold signed phase delay, reset zero.
// (RULE_02) Channel 1 config bits 15..6 hold signed phase delay, reset zero.
// (RULE_03) Channel 0 bits 1..0 pick input: pins, shorted, DC or AC diagnostic.
// (RULE_04) Channel 1 input select same, code 00 uses shared negative pin.
// (RULE_05) Offset upper register holds value bits 23..8 in all 16 bits.
// (RULE_06) Offset lower register holds value bits 7..0 in bits 15..8, reset zero.
// (RULE_07) Gain upper holds bits 23..8 of unsigned gain, reset 8000h, unity.
// (RULE_08) Gain lower holds gain bits 7..0 in bits 15..8, reset zero.
// (RULE_09) Reserved bits are read-only and always read zero.
// (RULE_10) Each 24-bit value updates as one word from both halves.
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic                  pclk,           // Clock, 40 MHz
  input  wire logic                  presetn,        // Async reset, low
  input  wire logic                  psel,           // APB select
  input  wire logic                  penable,        // APB enable
  input  wire logic                  pwrite,         // APB direction
  input  wire logic [CCR_ADDR_W-1:0] paddr,          // APB byte address
  input  wire logic [31:0]           pwdata,         // APB write data
  input  wire logic [3:0]            pstrb,          // APB byte strobes
  output logic [31:0]                prdata,         // APB read data
  output logic                       pready,         // APB ready
  output logic                       pslverr,        // APB error
  output ccr_chan_cfg_t              chan0_cfg,      // Channel 0 settings
  output ccr_chan_cfg_t              chan1_cfg,      // Channel 1 settings
  output ccr_cal_t                   cal,            // Applied corrections
  output logic                       cal_pending     // Half written, not applied
);

  ////////////////////////////////////////////////////////////////////////////
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  reg_idx;
  logic        misaligned;
  logic        hit;
  logic        wr_ok;
  logic [15:0] wdata16;

  logic [15:0] chan0_config_r;
  logic [15:0] ch0_ofs_u_r;
  logic [15:0] ch0_ofs_l_r;
  logic [15:0] ch0_gn_u_r;
  logic [15:0] ch0_gn_l_r;
  logic [15:0] chan1_config_r;
  logic [15:0] ch1_ofs_u_r;
  logic [15:0] ch1_ofs_l_r;
  logic [2:0]  upd_r;
  logic [15:0] rd_nxt;

  ccr_apb_slave u_slave (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .wr_stb     (wr_stb),
    .rd_stb     (rd_stb),
    .reg_idx    (reg_idx),
    .misaligned (misaligned)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by write and read paths
  function automatic logic known_idx(input logic [7:0] idx);
    case (idx)
      CCR_IDX_CHAN0_CONFIG, CCR_IDX_CH0_OFS_U, CCR_IDX_CH0_OFS_L,
      CCR_IDX_CH0_GN_U, CCR_IDX_CH0_GN_L, CCR_IDX_CHAN1_CONFIG,
      CCR_IDX_CH1_OFS_U, CCR_IDX_CH1_OFS_L, CCR_IDX_COMMIT: known_idx = 1'b1;
      default: known_idx = 1'b0;
    endcase
  endfunction

  // Byte-lane merge under a writable mask; reserved bits stay zero
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [3:0]  strb,
                                        input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    merge = v & mask;
  endfunction

  always_comb begin
    // Index bits above the decoded byte must be zero, or far addresses alias registers
    hit     = known_idx(reg_idx) && !misaligned && paddr == (CCR_ADDR_W'(reg_idx) << CCR_IDX_LSB);
    wr_ok   = wr_stb && hit;
    wdata16 = pwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan0_config_r <= CCR_RST_ZERO;
    end else if (wr_ok && reg_idx == CCR_IDX_CHAN0_CONFIG) begin
      chan0_config_r <= merge(chan0_config_r, wdata16, pstrb, CCR_MASK_CFG); // see (RULE_01) (RULE_09)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_config_r <= CCR_RST_ZERO;
    end else if (wr_ok && reg_idx == CCR_IDX_CHAN1_CONFIG) begin
      chan1_config_r <= merge(chan1_config_r, wdata16, pstrb, CCR_MASK_CFG); // see (RULE_02) (RULE_09)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration halves, staged until paired or committed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch0_ofs_u_r <= CCR_RST_ZERO;
      ch0_ofs_l_r <= CCR_RST_ZERO;
    end else if (wr_ok) begin
      if (reg_idx == CCR_IDX_CH0_OFS_U) begin
        ch0_ofs_u_r <= merge(ch0_ofs_u_r, wdata16, pstrb, CCR_MASK_UP); // see (RULE_05)
      end
      if (reg_idx == CCR_IDX_CH0_OFS_L) begin
        ch0_ofs_l_r <= merge(ch0_ofs_l_r, wdata16, pstrb, CCR_MASK_LOW); // see (RULE_06)
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch0_gn_u_r <= CCR_RST_GAIN_U; // see (RULE_07)
      ch0_gn_l_r <= CCR_RST_ZERO;   // see (RULE_08)
    end else if (wr_ok) begin
      if (reg_idx == CCR_IDX_CH0_GN_U) begin
        ch0_gn_u_r <= merge(ch0_gn_u_r, wdata16, pstrb, CCR_MASK_UP); // see (RULE_07)
      end
      if (reg_idx == CCR_IDX_CH0_GN_L) begin
        ch0_gn_l_r <= merge(ch0_gn_l_r, wdata16, pstrb, CCR_MASK_LOW); // see (RULE_08)
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch1_ofs_u_r <= CCR_RST_ZERO;
      ch1_ofs_l_r <= CCR_RST_ZERO;
    end else if (wr_ok) begin
      if (reg_idx == CCR_IDX_CH1_OFS_U) begin
        ch1_ofs_u_r <= merge(ch1_ofs_u_r, wdata16, pstrb, CCR_MASK_UP); // see (RULE_05)
      end
      if (reg_idx == CCR_IDX_CH1_OFS_L) begin
        ch1_ofs_l_r <= merge(ch1_ofs_l_r, wdata16, pstrb, CCR_MASK_LOW); // see (RULE_06)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pairing: a value is applied only once both of its halves have been
  // written since its last update, so the datapath never sees a mix of a
  // new upper half and an old lower half. Writing the commit register
  // forces all staged values out, for software that changes one half only.
  // Bit 0 chan0 offset, bit 1 chan0 gain, bit 2 chan1 offset.
  logic [2:0] up_seen_r;
  logic [2:0] lo_seen_r;
  logic [2:0] up_wr;
  logic [2:0] lo_wr;
  logic       commit_wr;

  always_comb begin
    up_wr[0]  = wr_ok && reg_idx == CCR_IDX_CH0_OFS_U;
    up_wr[1]  = wr_ok && reg_idx == CCR_IDX_CH0_GN_U;
    up_wr[2]  = wr_ok && reg_idx == CCR_IDX_CH1_OFS_U;
    lo_wr[0]  = wr_ok && reg_idx == CCR_IDX_CH0_OFS_L;
    lo_wr[1]  = wr_ok && reg_idx == CCR_IDX_CH0_GN_L;
    lo_wr[2]  = wr_ok && reg_idx == CCR_IDX_CH1_OFS_L;
    commit_wr = wr_ok && reg_idx == CCR_IDX_COMMIT;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_seen_r <= 3'b000;
      lo_seen_r <= 3'b000;
      upd_r     <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (commit_wr || ((up_seen_r[i] || up_wr[i]) && (lo_seen_r[i] || lo_wr[i]))) begin
          up_seen_r[i] <= 1'b0; // see (RULE_10)
          lo_seen_r[i] <= 1'b0;
          upd_r[i]     <= 1'b1;
        end else begin
          up_seen_r[i] <= up_seen_r[i] || up_wr[i];
          lo_seen_r[i] <= lo_seen_r[i] || lo_wr[i];
          upd_r[i]     <= 1'b0;
        end
      end
    end
  end

  // Transfer lags the completing write by one cycle so the staged halves are settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal.chan0_offset <= {CCR_RST_ZERO, CCR_RST_ZERO[7:0]};
      cal.chan0_gain   <= CCR_RST_GAIN_24; // see (RULE_07)
      cal.chan1_offset <= {CCR_RST_ZERO, CCR_RST_ZERO[7:0]};
    end else begin
      if (upd_r[0]) begin
        cal.chan0_offset <= {ch0_ofs_u_r, ch0_ofs_l_r[CCR_LOW_HI:CCR_LOW_LO]}; // see (RULE_10)
      end
      if (upd_r[1]) begin
        cal.chan0_gain <= {ch0_gn_u_r, ch0_gn_l_r[CCR_LOW_HI:CCR_LOW_LO]}; // see (RULE_10)
      end
      if (upd_r[2]) begin
        cal.chan1_offset <= {ch1_ofs_u_r, ch1_ofs_l_r[CCR_LOW_HI:CCR_LOW_LO]}; // see (RULE_10)
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_pending <= 1'b0;
    end else begin
      cal_pending <= |(up_seen_r | lo_seen_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel settings out to the converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan0_cfg <= '0;
      chan1_cfg <= '0;
    end else begin
      chan0_cfg.phase_delay  <= chan0_config_r[CCR_PHASE_HI:CCR_PHASE_LO]; // see (RULE_01)
      chan0_cfg.input_select <= ccr_mux_t'(chan0_config_r[CCR_MUX_HI:CCR_MUX_LO]); // see (RULE_03)
      chan1_cfg.phase_delay  <= chan1_config_r[CCR_PHASE_HI:CCR_PHASE_LO]; // see (RULE_02)
      // Code zero here means own positive pin against the shared negative pin
      chan1_cfg.input_select <= ccr_mux_t'(chan1_config_r[CCR_MUX_HI:CCR_MUX_LO]); // see (RULE_04)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    case (reg_idx)
      CCR_IDX_CHAN0_CONFIG:   rd_nxt = chan0_config_r & CCR_MASK_CFG; // see (RULE_09)
      CCR_IDX_CH0_OFS_U: rd_nxt = ch0_ofs_u_r;
      CCR_IDX_CH0_OFS_L: rd_nxt = ch0_ofs_l_r & CCR_MASK_LOW; // see (RULE_09)
      CCR_IDX_CH0_GN_U:  rd_nxt = ch0_gn_u_r;
      CCR_IDX_CH0_GN_L:  rd_nxt = ch0_gn_l_r & CCR_MASK_LOW;
      CCR_IDX_CHAN1_CONFIG:   rd_nxt = chan1_config_r & CCR_MASK_CFG;
      CCR_IDX_CH1_OFS_U: rd_nxt = ch1_ofs_u_r;
      CCR_IDX_CH1_OFS_L: rd_nxt = ch1_ofs_l_r & CCR_MASK_LOW;
      CCR_IDX_COMMIT:    rd_nxt = {13'h0000, up_seen_r | lo_seen_r};
      default:           rd_nxt = CCR_RST_ZERO;
    endcase
  end

  // Outputs registered: answer shows in the cycle after setup, ready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable && !pwrite && hit) begin
        prdata <= {16'h0000, rd_nxt};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Read strobe from the slave is unused; the write strobe feeds wr_ok without gating by ready
  logic unused_rd;
  always_comb begin
    unused_rd = rd_stb;
  end

endmodule

// ### ccr_regs_props.sv
`timescale 1ns/100ps
module ccr_props
  import ccr_pkg::*;
(
  input wire logic                  pclk,        // Clock
  input wire logic                  presetn,     // Reset, low
  input wire logic                  psel,        // Select
  input wire logic                  penable,     // Enable
  input wire logic                  pwrite,      // Direction
  input wire logic [CCR_ADDR_W-1:0] paddr,       // Address
  input wire logic [31:0]           pwdata,      // Write data
  input wire logic [3:0]            pstrb,       // Strobes
  input wire logic [31:0]           prdata,      // Read data
  input wire logic                  pready,      // Ready
  input wire logic                  pslverr,     // Error
  input wire ccr_chan_cfg_t         chan0_cfg,   // Channel 0
  input wire ccr_chan_cfg_t         chan1_cfg,   // Channel 1
  input wire ccr_cal_t              cal,         // Corrections
  input wire logic                  cal_pending  // Pending
);
  logic        rd_ok;
  logic        wr_ok;
  logic [11:0] cfg_in;
  assign rd_ok  = pready && !pwrite;
  assign wr_ok  = pready && pwrite && !pslverr;
  assign cfg_in = {pwdata[15:6], pwdata[1:0]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(a);
    pready && pwrite && paddr == a && pstrb[1:0] == 2'b11;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_ZERO_WAIT: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside access");
  AST_UPPER_ZERO: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_CFG_RSVD: assert property (rd_ok && paddr inside {12'h024, 12'h038} |-> prdata[5:2] == 4'h0)
    else $error("config reserved bits not zero");
  AST_LOW_RSVD: assert property (rd_ok && paddr inside {12'h02c, 12'h034, 12'h040} |-> prdata[7:0] == 8'h00)
    else $error("lower reserved bits not zero");
  AST_CHAN0_CONFIG: assert property (s_wr(12'h024) |-> ##2 chan0_cfg == $past(cfg_in, 2))
    else $error("channel 0 settings not from write");
  AST_CHAN1_CONFIG: assert property (s_wr(12'h038) |-> ##2 chan1_cfg == $past(cfg_in, 2))
    else $error("channel 1 settings not from write");
  AST_CAL_CAUSE: assert property ($changed(cal) |-> $past(wr_ok, 2) || $past(wr_ok, 3))
    else $error("corrections changed without write");
  AST_PEND_CAUSE: assert property ($rose(cal_pending) |-> $past(wr_ok) || $past(wr_ok, 2))
    else $error("pending rose without write");
  AST_CFG_HOLD: assert property ($changed(chan0_cfg) |-> $past(wr_ok, 2))
    else $error("channel 0 settings changed alone");
  AST_MISALIGN: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
endmodule
bind ccr_regs ccr_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan0_cfg(chan0_cfg),
  .chan1_cfg(chan1_cfg), .cal(cal), .cal_pending(cal_pending));

// ### test_ccr_regs.sv
`timescale 1ns/100ps
module test_ccr_regs
  import ccr_pkg::*;
;
  typedef struct packed {
    logic        w;
    logic [15:0] d;
    logic        e;
  } ccr_note_t;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata;
  logic [3:0]    pstrb = '0;
  logic          pready, pslverr, cal_pending;
  logic [23:0]   old;
  ccr_chan_cfg_t chan0_cfg, chan1_cfg;
  ccr_cal_t      cal;
  ccr_note_t     q[$], nt;
  logic [15:0]   sh[8];
  int            fails = 0, checks = 0;
  localparam logic [15:0] MSK[8] = '{CCR_MASK_CFG, CCR_MASK_UP, CCR_MASK_LOW, CCR_MASK_UP,
                                     CCR_MASK_LOW, CCR_MASK_CFG, CCR_MASK_UP, CCR_MASK_LOW};
  always #12.5 pclk = ~pclk;
  ccr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan0_cfg(chan0_cfg), .chan1_cfg(chan1_cfg),
    .cal(cal), .cal_pending(cal_pending));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Entered just after a rising edge; leaves one idle edge so psel is never set twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic [3:0] s, input logic [15:0] e, input logic er);
    int n;
    n = 0;
    q.push_back(ccr_note_t'{w, e, er});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {16'($urandom), d};
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      complete_run();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = MSK[i] & {{8{s[1]}}, {8{s[0]}}};
    sh[i] = (sh[i] & ~m) | (d & m);
    apb(1'b1, 12'h024 + 12'(4 * i), d, s, 16'h0000, 1'b0);
  endtask
  task automatic rd(input int i);
    apb(1'b0, 12'h024 + 12'(4 * i), 16'h0000, 4'h0, sh[i], 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) chk("note", 32'h1, 32'h0);
      else begin
        nt = q.pop_front();
        chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
        if (!nt.w) chk("prdata", {16'h0000, nt.d}, prdata);
      end
    end
  end
  initial begin
    void'($urandom(32'h92fb_6965));
    for (int i = 0; i < 8; i++) sh[i] = (i == 3) ? CCR_RST_GAIN_U : CCR_RST_ZERO;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rd(i);
    chk("gain", {8'h00, CCR_RST_GAIN_24}, {8'h00, cal.chan0_gain});
    chk("cfg", 32'h0, {8'h00, chan0_cfg, chan1_cfg});
    $display("test reset done");
    // Reserved config bits written as ones must stay zero
    for (int k = 0; k < 4; k++) begin
      wr(0, {10'h200 + 10'(k), 4'hf, 2'(k)}, 4'h3);
      wr(5, {10'h1ff, 4'hf, 2'(k)}, 4'h3);
      rd(0);
      rd(5);
      chk("ch0", {20'h0, 10'h200 + 10'(k), 2'(k)}, {20'h0, chan0_cfg});
      chk("ch1", {20'h0, 10'h1ff, 2'(k)}, {20'h0, chan1_cfg});
    end
    $display("test select done");
    for (int n = 0; n < 16; n++) begin
      int i;
      i = $urandom_range(7);
      wr(i, 16'($urandom), 4'($urandom));
      rd(i);
    end
    $display("test random done");
    apb(1'b1, 12'h060, 16'h0000, 4'h3, 16'h0000, 1'b0);
    apb(1'b0, 12'h060, 16'h0000, 4'h0, 16'h0000, 1'b0);
    old = {sh[1], sh[2][15:8]};
    wr(1, 16'h8001, 4'h3);
    repeat (3) @(posedge pclk);
    chk("pend", 32'h1, {31'h0, cal_pending});
    chk("ofs0", {8'h00, old}, {8'h00, cal.chan0_offset});
    wr(2, 16'h7f00, 4'h3);
    repeat (3) @(posedge pclk);
    chk("ofs0", {8'h00, 24'h80_017f}, {8'h00, cal.chan0_offset});
    chk("pend", 32'h0, {31'h0, cal_pending});
    wr(4, 16'hab00, 4'h3);
    wr(3, 16'hffff, 4'h3);
    repeat (3) @(posedge pclk);
    chk("gain0", {8'h00, 24'hff_ffab}, {8'h00, cal.chan0_gain});
    wr(6, 16'($urandom), 4'h3);
    apb(1'b0, 12'h060, 16'h0000, 4'h0, 16'h0004, 1'b0);
    apb(1'b1, 12'h060, 16'h0000, 4'h3, 16'h0000, 1'b0);
    repeat (3) @(posedge pclk);
    chk("ofs1", {8'h00, sh[6], sh[7][15:8]}, {8'h00, cal.chan1_offset});
    $display("test pairing done");
    apb(1'b0, 12'h044, 16'h0000, 4'h0, 16'h0000, 1'b1);
    apb(1'b1, 12'h025, 16'hffff, 4'h3, 16'h0000, 1'b1);
    rd(0);
    // Far addresses whose low index bits match a register must be refused
    apb(1'b0, 12'h424, 16'h0000, 4'h0, 16'h0000, 1'b1);
    apb(1'b1, 12'h428, 16'hffff, 4'h3, 16'h0000, 1'b1);
    rd(1);
    $display("test refusal done");
    complete_run();
  end
endmodule
